// file: test/gcdr_panel.sv
// Purpose: panel model that captures each driven common row
// Assumes: one-hot common select, segments stable while selected
// Notes: seen marks every common the device has selected since the last clr
`timescale 1ns/100ps
`default_nettype none
module gcdr_panel
(
  // Clock and clear
  input wire logic sys_clk,
  input wire logic clr,
  // Electrodes
  input wire logic [15:0] com_sel,
  input wire logic [39:0] seg_out,
  // Captured image
  output logic [15:0] seen,
  output logic [39:0] img [16]
);
  always_ff @(posedge sys_clk)
  begin
    if (clr)
      seen <= 16'h0000;
    for (int i = 0; i < 16; i++)
      if (com_sel[i])
      begin
        seen[i] <= 1'b1;
        img[i] <= seg_out;
      end
  end
endmodule : gcdr_panel
`default_nettype wire

// file: test/tb_top.sv
// Purpose: random frames checked against the glyph map
// Assumes: 8 text positions, fixed store modelled as an xor
// Notes: writes held 3 cycles so a refresh slot never drops them
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clr = 1'b0;
  gcdr_pkg::gcdr_ctrl_t ctrl = 4'h4;
  gcdr_pkg::gcdr_host_t host = '0;
  logic [6:0] pointer_reg = 7'h00;
  logic [7:0] host_rdata, text_code;
  logic [6:0] text_addr;
  logic [11:0] rom_addr;
  logic [4:0] rom_row;
  logic [15:0] com_sel, seen;
  logic [39:0] seg_out;
  logic [39:0] img [16];
  logic [7:0] ram [64];
  logic [7:0] txt [8];
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'h2f27_9fc9;
  always #50 sys_clk = ~sys_clk;
  assign text_code = txt[text_addr[2:0]];
  assign rom_row = rom_addr[4:0] ^ rom_addr[11:7];
  gcdr_readout gcdr_readout_i (.sys_clk(sys_clk), .rst_n(rst_n), .ctrl(ctrl), .pointer_reg(pointer_reg),
    .host(host), .host_rdata(host_rdata), .text_addr(text_addr), .text_code(text_code),
    .rom_addr(rom_addr), .rom_row(rom_row), .com_sel(com_sel), .seg_out(seg_out));
  gcdr_panel gcdr_panel_i (.sys_clk(sys_clk), .clr(clr), .com_sel(com_sel), .seg_out(seg_out),
    .seen(seen), .img(img));
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : step
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic hacc(input logic w, input logic [5:0] a, input logic [7:0] d);
    host = '{w, a, d};
    step(3);
    host.wr = 1'b0;
    step(1);
  endtask : hacc
  task automatic close_out();
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  function automatic logic [39:0] exp_row(input logic f10, input logic [3:0] r);
    logic [39:0] v;
    logic [7:0] c;
    logic [4:0] d;
    v = '0;
    for (int a = 0; a < 8; a++)
    begin
      c = txt[a];
      d = f10 ? ram[{c[2:1], r}][4:0] : ram[{c[2:0], r[2:0]}][4:0];
      if (c[7:4] != 4'h0)
        d = {c[0], r} ^ c[7:3];
      if (ctrl.cursor_on && a == pointer_reg && r == (f10 ? 4'hA : 4'h7))
        d = 5'h1F;
      v[a*5 +: 5] = d;
    end
    return v;
  endfunction : exp_row
  initial
  begin
    for (int a = 0; a < 8; a++)
      txt[a] = 8'h00;
    step(5);
    rst_n = 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      ram[i] = 8'($random(seed));
      if (i[2:0] == 3'h7 || i[3:0] == 4'hA)
        ram[i][4:0] = 5'h00;
      hacc(1'b1, 6'(i), ram[i]);
    end
    for (int i = 0; i < 64; i++)
    begin
      hacc(1'b0, 6'(i), 8'h00);
      check(40'(host_rdata), 40'(ram[i]));
    end
    for (int ph = 0; ph < 8; ph++)
    begin
      // Pointer beyond the 8 positions must show no cursor
      // Whole run sits inside the first blink half period, so blink must not show yet
      ctrl = '{ph[0], 1'b1, ph[1], ph[2]};
      pointer_reg = 7'($random(seed)) & 7'h0F;
      for (int a = 0; a < 8; a++)
        txt[a] = 8'($random(seed)) & (a < 5 ? 8'h0F : 8'hFF);
      step(800);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(400);
      check(40'(seen), ph[0] ? 40'h7FF : 40'hFF);
      for (int r = 0; r < (ph[0] ? 11 : 8); r++)
        check(img[r], exp_row(ph[0], 4'(r)));
    end
    ctrl.disp_on = 1'b0;
    step(100);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(400);
    check(40'(seen), 40'h0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire

// file: verilog/gcdr_map.svh
// Purpose: constants for the glyph readout block
// Assumes: 10 MHz sys_clk
// Notes: definitions only
`ifndef GCDR_MAP_SVH
`define GCDR_MAP_SVH
`define GCDR_NUM_COM 16
`define GCDR_NUM_SEG 40
`define GCDR_NUM_CHAR 8
`define GCDR_CHAR_W 6'h08
`define GCDR_LAST_ADDR 7'h07
`define GCDR_CURSOR_ROW8 4'h7
`define GCDR_CURSOR_ROW10 4'hA
`define GCDR_ROWS8 4'h8
`define GCDR_ROWS10 4'hB
`define GCDR_BLINK_DIV 22'h0F_4240
`define GCDR_SLOT_PH 2'h0
`endif

// file: verilog/gcdr_pkg.sv
// Purpose: types for the glyph readout block
// Assumes: constants live in gcdr_map.svh
// Notes: none
`default_nettype none
package gcdr_pkg;
  typedef enum logic [1:0] {
    GCDR_IDLE = 2'b00,
    GCDR_FETCH = 2'b01,
    GCDR_SHIFT = 2'b10,
    GCDR_LATCH = 2'b11
  } gcdr_state_t;
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] data;
  } gcdr_host_t;
  typedef struct packed {
    logic font10;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
  } gcdr_ctrl_t;
endpackage : gcdr_pkg
`default_nettype wire

// file: verilog/gcdr_readout.sv
// Purpose: character glyph readout with cursor, blink and driver shift
// Assumes: text_buffer read port is combinational; fixed glyph store external
// Notes: one row of 8 chars at 5 dots; frame restarts after the last row
//
// Summary of operation
// - 5x8: code bits 2:0 pick glyph
// - 5x8: address bits 2:0 pick line
// - 5x8: eighth line ORed with cursor
// - Data bits 4:0 are dots, bit4 left
// - Code bits 7:4 zero selects RAM glyph
// - 5x8: code bit 3 ignored
// - One bit lights dot, zero unlit
// - 5x10: code bits 2:1 pick glyph
// - 5x10: bits 3:0 line, eleventh cursor
// - 5x10: lines 12-16 hidden, still storage
// - 5x10: code bits 0,3 ignored
// - Host and refresh accesses use separate slots
// - 16 commons, 40 segments, unused unselected
// - Shift starts at last text address
// - Latch when starting address enters
// - Cursor at pointer_reg address
// - Cursor and blink gated by enables
`timescale 1ns/100ps
`default_nettype none
`include "gcdr_map.svh"
module gcdr_readout
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire gcdr_pkg::gcdr_ctrl_t ctrl,
  input wire logic [6:0] pointer_reg,
  // Host access to user glyph RAM
  input wire gcdr_pkg::gcdr_host_t host,
  output logic [7:0] host_rdata,
  // Text buffer read port
  output logic [6:0] text_addr,
  input wire logic [7:0] text_code,
  // Fixed glyph store read port
  output logic [11:0] rom_addr,
  input wire logic [4:0] rom_row,
  // Panel drivers
  output logic [15:0] com_sel,
  output logic [39:0] seg_out
);
  logic [7:0] glyph_ram [0:63];
  logic [1:0] slot_r;
  logic [3:0] row_r;
  logic [2:0] pos_r;
  logic [39:0] shreg_r;
  logic [39:0] seg_r;
  logic [15:0] com_r;
  logic [7:0] hrd_r;
  logic [21:0] blink_cnt_r;
  logic blink_ph_r;
  logic [3:0] rows_used;
  logic [3:0] cursor_row;
  logic is_user;
  logic [5:0] user_addr;
  logic [4:0] pattern;
  logic cursor_here;
  logic [4:0] merged;
  logic refresh_slot;
  logic last_pos;
  logic [6:0] char_addr;
  logic [7:0] ram_word;

  assign refresh_slot = (slot_r == `GCDR_SLOT_PH);
  assign rows_used = ctrl.font10 ? `GCDR_ROWS10 : `GCDR_ROWS8;
  assign cursor_row = ctrl.font10 ? `GCDR_CURSOR_ROW10 : `GCDR_CURSOR_ROW8;
  // Walk from the last address down so the start address arrives last
  assign char_addr = `GCDR_LAST_ADDR - {4'h0, pos_r};
  assign text_addr = char_addr;
  assign is_user = (text_code[7:4] == 4'h0);
  assign user_addr = ctrl.font10
    ? {text_code[2:1], row_r}
    : {text_code[2:0], row_r[2:0]};
  assign ram_word = glyph_ram[user_addr];
  assign rom_addr = {text_code, row_r};
  assign pattern = is_user ? ram_word[4:0] : rom_row;
  assign cursor_here = (char_addr == pointer_reg) && (row_r == cursor_row);
  assign merged = (ctrl.blink_on && blink_ph_r && char_addr == pointer_reg) ? 5'h1F
    : (pattern | {5{cursor_here && ctrl.cursor_on}});
  assign last_pos = (pos_r == 3'h7);
  assign host_rdata = hrd_r;
  assign com_sel = com_r;
  assign seg_out = seg_r;

  // Host cycles only in non-refresh slots; rows 11-15 stay plain storage
  always_ff @(posedge sys_clk)
  begin
    if (host.wr && !refresh_slot)
      glyph_ram[host.addr] <= host.data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hrd_r <= 8'h00;
    else if (!refresh_slot)
      hrd_r <= glyph_ram[host.addr];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      slot_r <= 2'h0;
    else
      slot_r <= slot_r + 2'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      blink_cnt_r <= 22'h00_0000;
      blink_ph_r <= 1'b0;
    end
    else if (blink_cnt_r == `GCDR_BLINK_DIV)
    begin
      blink_cnt_r <= 22'h00_0000;
      blink_ph_r <= ~blink_ph_r;
    end
    else
      blink_cnt_r <= blink_cnt_r + 22'h00_0001;
  end

  // Shift one character per refresh slot; latch after start address enters
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pos_r <= 3'h0;
      row_r <= 4'h0;
      shreg_r <= 40'h00_0000_0000;
    end
    else if (refresh_slot)
    begin
      shreg_r <= {shreg_r[34:0], merged};
      pos_r <= pos_r + 3'h1;
      if (last_pos)
        row_r <= (row_r + 4'h1 >= rows_used) ? 4'h0 : row_r + 4'h1;
    end
  end

  logic latch_r;
  logic [3:0] latch_row_r;
  logic row_shown;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      latch_r <= 1'b0;
      latch_row_r <= 4'h0;
    end
    else
    begin
      latch_r <= refresh_slot && last_pos;
      if (refresh_slot && last_pos)
        latch_row_r <= row_r;
    end
  end

  // A font change mid-frame can finish one row past the new height; its common stays unselected
  assign row_shown = (latch_row_r < rows_used);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      seg_r <= 40'h00_0000_0000;
      com_r <= 16'h0000;
    end
    else if (latch_r)
    begin
      seg_r <= ctrl.disp_on ? shreg_r : 40'h00_0000_0000;
      com_r <= (ctrl.disp_on && row_shown) ? (16'h0001 << latch_row_r) : 16'h0000;
    end
  end

  // Row walk: the start address closes a row and one latch pulse follows
  sequence s_row_done;
    refresh_slot && last_pos;
  endsequence
  sequence s_latch_pulse;
    latch_r ##1 !latch_r;
  endsequence

  property p_latch_follows_last;
    @(posedge sys_clk) disable iff (!rst_n)
    s_row_done |=> s_latch_pulse;
  endproperty
  a_latch_follows_last: assert property (p_latch_follows_last) else $error("latch missed");
  property p_seg_load;
    @(posedge sys_clk) disable iff (!rst_n)
    (latch_r && ctrl.disp_on) |=> seg_r == $past(shreg_r);
  endproperty
  a_seg_load: assert property (p_seg_load) else $error("segments not loaded from shift register");
  property p_seg_stand;
    @(posedge sys_clk) disable iff (!rst_n)
    !latch_r |=> ($stable(seg_r) && $stable(com_r));
  endproperty
  a_seg_stand: assert property (p_seg_stand) else $error("drivers changed between latches");
  property p_char_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    s_row_done |=> char_addr == `GCDR_LAST_ADDR;
  endproperty
  a_char_wrap: assert property (p_char_wrap) else $error("row did not restart at last address");

  property p_slot_gap;
    @(posedge sys_clk) disable iff (!rst_n)
    refresh_slot |=> !refresh_slot [*3];
  endproperty
  a_slot_gap: assert property (p_slot_gap) else $error("refresh slot spacing");
  property p_hold_in_refresh;
    @(posedge sys_clk) disable iff (!rst_n)
    refresh_slot |=> $stable(hrd_r);
  endproperty
  a_hold_in_refresh: assert property (p_hold_in_refresh) else $error("host read in refresh slot");

  property p_com_onehot;
    @(posedge sys_clk) disable iff (!rst_n)
    $onehot0(com_r);
  endproperty
  a_com_onehot: assert property (p_com_onehot) else $error("common not one-hot");
  property p_com_range;
    @(posedge sys_clk) disable iff (!rst_n)
    latch_r |=> (com_r >> $past(rows_used)) == 16'h0000;
  endproperty
  a_com_range: assert property (p_com_range) else $error("unused common selected");
  property p_com_row;
    @(posedge sys_clk) disable iff (!rst_n)
    (latch_r && ctrl.disp_on && row_shown) |=> com_r == (16'h0001 << $past(latch_row_r));
  endproperty
  a_com_row: assert property (p_com_row) else $error("wrong common for latched row");
  property p_dark_off;
    @(posedge sys_clk) disable iff (!rst_n)
    (latch_r && !ctrl.disp_on) |=> (seg_r == 40'h00_0000_0000 && com_r == 16'h0000);
  endproperty
  a_dark_off: assert property (p_dark_off) else $error("drivers active with display off");
  property p_row_bound;
    @(posedge sys_clk) disable iff (!rst_n)
    row_r <= `GCDR_CURSOR_ROW10;
  endproperty
  a_row_bound: assert property (p_row_bound) else $error("row beyond tallest font");

  property p_user_sel;
    @(posedge sys_clk) disable iff (!rst_n)
    (is_user && !ctrl.font10) |-> user_addr[5:3] == text_code[2:0];
  endproperty
  a_user_sel: assert property (p_user_sel) else $error("5x8 glyph select");
  property p_user_line8;
    @(posedge sys_clk) disable iff (!rst_n)
    (is_user && !ctrl.font10) |-> user_addr[2:0] == row_r[2:0];
  endproperty
  a_user_line8: assert property (p_user_line8) else $error("5x8 line select");
  property p_user_sel10;
    @(posedge sys_clk) disable iff (!rst_n)
    (is_user && ctrl.font10) |-> user_addr[5:4] == text_code[2:1];
  endproperty
  a_user_sel10: assert property (p_user_sel10) else $error("5x10 glyph select");
  property p_user_line10;
    @(posedge sys_clk) disable iff (!rst_n)
    (is_user && ctrl.font10) |-> user_addr[3:0] == row_r;
  endproperty
  a_user_line10: assert property (p_user_line10) else $error("5x10 line select");
  property p_user_dots;
    @(posedge sys_clk) disable iff (!rst_n)
    (is_user && !ctrl.cursor_on && !ctrl.blink_on) |-> merged == ram_word[4:0];
  endproperty
  a_user_dots: assert property (p_user_dots) else $error("user glyph dots altered");
  property p_fixed_path;
    @(posedge sys_clk) disable iff (!rst_n)
    (!is_user && !ctrl.cursor_on && !ctrl.blink_on) |-> merged == rom_row;
  endproperty
  a_fixed_path: assert property (p_fixed_path) else $error("fixed glyph dots altered");

  property p_cursor_or;
    @(posedge sys_clk) disable iff (!rst_n)
    (cursor_here && ctrl.cursor_on) |-> merged == 5'h1F;
  endproperty
  a_cursor_or: assert property (p_cursor_or) else $error("cursor not merged");
  property p_cursor_row_only;
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl.cursor_on && !ctrl.blink_on && row_r != cursor_row) |-> merged == pattern;
  endproperty
  a_cursor_row_only: assert property (p_cursor_row_only) else $error("cursor outside cursor line");
  property p_no_cursor;
    @(posedge sys_clk) disable iff (!rst_n)
    (!ctrl.cursor_on && !ctrl.blink_on) |-> merged == pattern;
  endproperty
  a_no_cursor: assert property (p_no_cursor) else $error("pattern altered");
  property p_blink_force;
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl.blink_on && blink_ph_r && char_addr == pointer_reg) |-> merged == 5'h1F;
  endproperty
  a_blink_force: assert property (p_blink_force) else $error("blink phase not shown");
  property p_blink_div;
    @(posedge sys_clk) disable iff (!rst_n)
    blink_cnt_r <= `GCDR_BLINK_DIV;
  endproperty
  a_blink_div: assert property (p_blink_div) else $error("blink counter overran");
endmodule : gcdr_readout
`default_nettype wire
